// file: src/card_mem_pkg.sv
// Shared constants and types for the serial card memory
package card_mem_pkg;
	localparam logic [7:0] CTL_RD_MAIN  = 8'h30;
	localparam logic [7:0] CTL_UPD_MAIN = 8'h38;
	localparam logic [7:0] CTL_RD_PROT  = 8'h34;
	localparam logic [7:0] CTL_WR_PROT  = 8'h3c;
	localparam logic [7:0] CTL_RD_SEC   = 8'h31;
	localparam logic [7:0] CTL_UPD_SEC  = 8'h39;
	localparam logic [7:0] CTL_COMPARE  = 8'h33;
	localparam int PHASE_TIME_NS = 2500000;
	localparam int REF_CLK_NS    = 50;
	// Least time, so round up
	localparam int PHASE_CYCLES  = (PHASE_TIME_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam logic [8:0] CLK_BOTH  = 9'h0ff;
	localparam logic [8:0] CLK_ONE   = 9'h07c;
	localparam logic [5:0] ATR_BITS  = 6'h20;
	localparam logic [5:0] CMD_BITS  = 6'h18;
	localparam logic [5:0] CMD_CLKS  = 6'h19;
	localparam logic [7:0] PROT_SPAN = 8'h20;
	localparam logic [8:0] MAIN_SIZE = 9'h100;
	localparam logic [8:0] AUX_BYTES = 9'h004;
	localparam logic [7:0] MEM_RESET = 8'hff;
	localparam logic [7:0] EC_RESET  = 8'h07;
	localparam logic [23:0] CODE_RESET = 24'hffffff;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_ATR  = 3'h1,
		M_CMD  = 3'h3,
		M_OUT  = 3'h2,
		M_PROC = 3'h6
	} mode_t;

	typedef enum logic [1:0] {K_MAIN = 2'h0, K_PROT = 2'h1, K_SEC = 2'h2} rdkind_t;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] addr;
		logic [7:0] ctrl;
	} cmd_t;

	typedef struct packed {
		logic [2:0]        clkSy;
		logic [2:0]        rstSy;
		logic [2:0]        ioSy;
		mode_t             mode;
		logic              oeN;
		logic [5:0]        bitCnt;
		cmd_t              cmd;
		logic [255:0][7:0] mem;
		logic [31:0]       prot;
		logic [3:0][7:0]   sec;
		logic              unlocked;
		logic [1:0]        cmpStep;
		logic              eraseP;
		logic              writeP;
		logic [16:0]       timer;
		logic [8:0]        tclk;
		logic [8:0]        tclkGoal;
		rdkind_t           pfKind;
		logic [7:0]        pfAddr;
		logic [8:0]        pfLeft;
		logic [7:0]        outByte;
		logic [2:0]        outBit;
		logic              haveByte;
	} state_t;
endpackage : card_mem_pkg

// file: src/card_chip.sv
// Card-side protocol engine with byte FIFO for the serial secure memory
// Contract
// - Erase sets all eight bits to one
// - Write stores old AND new byte
// - Skip erase when no zero-to-one change
// - Skip write when no one-to-zero change
// - Each erase or write phase lasts 2.5 ms
// - Protection bit N locks byte N below 32
// - Protection bits are never erased
// - Security: error counter plus 3-byte code
// - Readable variant: code hidden, writes locked
// - Protected variant: nothing accessible until verified
// - Spent error counter blocks further verification
// - Data line changes only on falling clock; the code also moves it when reset rises, is high or falls
// - Reset clears address, falling reset outputs bit0
// - Answer-to-reset 32 bits, 33rd clock releases
// - Start and stop ignored during answer-to-reset
// - Start/stop are data edges with clock high
// - Bytes control, address, data, LSB first
// - Reads stream out, others enter processing; the code sends blocked or unknown commands straight to idle
// - Outgoing data, extra clock then release
// - Processing pulls low until work completes
// - Main read streams from N to end
// - Update takes 255 or 124 terminal clocks
// - Failures release line within 8 clocks
// - Reset high with clock low aborts
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] buf_;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} fifo_t;
	fifo_t f_r;
	fifo_t f_nxt;
	logic  push;
	logic  pop;

	// Honest full and empty from the fill count
	assign inReady  = f_r.cnt != (AW+1)'(DEPTH);
	assign outValid = f_r.cnt != '0;
	assign outData  = f_r.buf_[f_r.rd];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Pointer and count update
	always_comb begin
		f_nxt = f_r;
		if (push) begin
			f_nxt.buf_[f_r.wr] = inData;
			f_nxt.wr = f_r.wr + 1'b1;
		end
		if (pop)
			f_nxt.rd = f_r.rd + 1'b1;
		f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush)
			f_nxt = '0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			f_r <= '0;
		else
			f_r <= f_nxt;
	end
endmodule : byte_fifo

module card_chip import card_mem_pkg::*; #(
	parameter int PHASE_CYC  = PHASE_CYCLES,
	parameter bit READ_LOCK  = 1'b0,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic cardClk,
	input  wire logic cardRst,
	input  wire logic ioIn,
	output logic      ioOut,
	output logic      ioOe_n
);
	state_t     st_r;
	state_t     st_nxt;
	logic       clkHi;
	logic       clkRise;
	logic       clkFall;
	logic       rstHi;
	logic       rstRise;
	logic       rstFall;
	logic       startC;
	logic       stopC;
	logic       pushV;
	logic       pushR;
	logic [7:0] pushD;
	logic       popV;
	logic       popR;
	logic [7:0] popD;
	logic       flushQ;
	logic       wrBlock;
	logic       needErase;
	logic       needWrite;
	logic [7:0] oldByte;
	logic [5:0] atrIdx;
	logic       breakNow;

	// Byte presented by the prefetcher; hidden data reads as zeros
	function automatic logic [7:0] fetchByte(input state_t s, input logic vis);
		logic [7:0] b;
		b = 8'h00;
		case (s.pfKind)
			K_MAIN: b = s.mem[s.pfAddr];
			K_PROT: b = s.prot[{s.pfAddr[1:0], 3'h0} +: 8];
			K_SEC: b = (s.pfAddr[1:0] == 2'h0 || s.unlocked) ? s.sec[s.pfAddr[1:0]] : 8'h00;
			default: b = 8'h00;
		endcase
		return vis ? b : 8'h00;
	endfunction : fetchByte

	// Edges seen on the synchronised pins; stage 0 only feeds stage 1
	assign clkHi   = st_r.clkSy[1];
	assign clkRise = st_r.clkSy[1] & ~st_r.clkSy[2];
	assign clkFall = ~st_r.clkSy[1] & st_r.clkSy[2];
	assign rstHi   = st_r.rstSy[1];
	assign rstRise = st_r.rstSy[1] & ~st_r.rstSy[2];
	assign rstFall = ~st_r.rstSy[1] & st_r.rstSy[2];
	assign startC  = clkHi & st_r.clkSy[2] & st_r.ioSy[2] & ~st_r.ioSy[1];
	assign stopC   = clkHi & st_r.clkSy[2] & ~st_r.ioSy[2] & st_r.ioSy[1];
	// Break: reset pin rising while the clock pin is low
	assign breakNow = rstRise & ~clkHi;
	// Next answer-to-reset bit; carries into the next byte after bit 7
	assign atrIdx   = st_r.bitCnt + 6'h01;

	assign ioOut  = 1'b0;
	assign ioOe_n = st_r.oeN;

	// Prefetched read bytes; the shifter stalls the fill when slow
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (ref_clk),
		.reset_n  (reset_n),
		.flush    (flushQ),
		.inValid  (pushV),
		.inReady  (pushR),
		.inData   (pushD),
		.outValid (popV),
		.outReady (popR),
		.outData  (popD)
	);

	// Access checks for the command held in the shift register
	always_comb begin
		oldByte = (st_r.cmd.ctrl == CTL_UPD_SEC) ? st_r.sec[st_r.cmd.addr[1:0]]
			: st_r.mem[st_r.cmd.addr];
		// erase only on a zero-to-one change
		needErase = |(~oldByte & st_r.cmd.data);
		// write only on a one-to-zero change
		needWrite = |(oldByte & ~st_r.cmd.data);
		wrBlock = 1'b1;
		case (st_r.cmd.ctrl)
			CTL_UPD_MAIN: wrBlock = !st_r.unlocked
				|| (st_r.cmd.addr < PROT_SPAN && st_r.prot[st_r.cmd.addr[4:0]]);
			// a set bit is a failure, never erased
			CTL_WR_PROT: wrBlock = !st_r.unlocked || st_r.cmd.addr >= PROT_SPAN
				|| st_r.prot[st_r.cmd.addr[4:0]]
				|| st_r.mem[st_r.cmd.addr] != st_r.cmd.data;
			// locked: only clear error counter bits
			CTL_UPD_SEC: wrBlock = !st_r.unlocked
				&& (st_r.cmd.addr[1:0] != 2'h0 || needErase || !needWrite);
			CTL_COMPARE: wrBlock = st_r.sec[0][2:0] == 3'h0 || st_r.cmpStep == 2'h0
				|| st_r.cmd.addr[1:0] != st_r.cmpStep
				|| st_r.cmd.data != st_r.sec[st_r.cmpStep];
			default: wrBlock = 1'b1;
		endcase
	end

	// Whole protocol step
	always_comb begin
		st_nxt = st_r;
		st_nxt.clkSy = {st_r.clkSy[1:0], cardClk};
		st_nxt.rstSy = {st_r.rstSy[1:0], cardRst};
		st_nxt.ioSy  = {st_r.ioSy[1:0], ioIn};
		popR   = 1'b0;
		flushQ = 1'b0;
		pushV  = st_r.pfLeft != 9'h000;
		pushD  = fetchByte(st_r, st_r.unlocked || !READ_LOCK);
		if (pushV && pushR) begin
			st_nxt.pfAddr = st_r.pfAddr + 8'h01;
			st_nxt.pfLeft = st_r.pfLeft - 9'h001;
		end
		// Phase timer runs on the reference clock, not the card clock
		// phase length
		if (st_r.eraseP || st_r.writeP)
			st_nxt.timer = st_r.timer + 17'h00001;
		if ((st_r.eraseP || st_r.writeP) && st_r.timer == 17'(PHASE_CYC - 1)) begin
			st_nxt.timer = '0;
			if (st_r.eraseP) begin
				st_nxt.eraseP = 1'b0;
				if (st_r.cmd.ctrl == CTL_UPD_SEC)
					st_nxt.sec[st_r.cmd.addr[1:0]] = MEM_RESET;
				else
					st_nxt.mem[st_r.cmd.addr] = MEM_RESET;
			end else begin
				st_nxt.writeP = 1'b0;
				if (st_r.cmd.ctrl == CTL_WR_PROT)
					st_nxt.prot[st_r.cmd.addr[4:0]] = 1'b1;
				else if (st_r.cmd.ctrl == CTL_UPD_SEC)
					st_nxt.sec[st_r.cmd.addr[1:0]] =
						st_r.sec[st_r.cmd.addr[1:0]] & st_r.cmd.data;
				else
					st_nxt.mem[st_r.cmd.addr] = st_r.mem[st_r.cmd.addr] & st_r.cmd.data;
			end
		end
		if (clkFall && st_r.tclk != 9'h1ff)
			st_nxt.tclk = st_r.tclk + 9'h001;
		if (breakNow) begin
			st_nxt.mode = M_IDLE;
			st_nxt.oeN = 1'b1;
			st_nxt.timer = '0;
			st_nxt.eraseP = 1'b0;
			st_nxt.writeP = 1'b0;
			st_nxt.pfLeft = '0;
			st_nxt.haveByte = 1'b0;
			flushQ = 1'b1;
		end else if (rstHi) begin
			// clocked reset clears the address counter
			if (clkRise)
				st_nxt.bitCnt = '0;
			st_nxt.mode = M_IDLE;
			st_nxt.oeN = 1'b1;
			// A read cut by reset must not leave bytes for the next read
			st_nxt.pfLeft = '0;
			st_nxt.haveByte = 1'b0;
			flushQ = 1'b1;
		end else if (rstFall) begin
			// first bit out as reset falls
			st_nxt.mode = M_ATR;
			st_nxt.bitCnt = '0;
			st_nxt.oeN = READ_LOCK ? 1'b1 : st_r.mem[0][0];
		end else begin
			case (st_r.mode)
				// no start or stop is looked at here
				M_ATR: begin
					if (clkFall) begin
						st_nxt.bitCnt = st_r.bitCnt + 6'h01;
						if (st_r.bitCnt + 6'h01 == ATR_BITS) begin
							st_nxt.oeN = 1'b1;
							st_nxt.mode = M_IDLE;
						end else begin
							st_nxt.oeN = READ_LOCK ? 1'b1
								: st_r.mem[{6'h00, atrIdx[4:3]}][atrIdx[2:0]];
						end
					end
				end
				M_IDLE: begin
					if (startC) begin
						st_nxt.mode = M_CMD;
						st_nxt.bitCnt = '0;
					end
				end
				M_CMD: begin
					if (clkRise && st_r.bitCnt < CMD_BITS)
						st_nxt.cmd = {st_r.clkSy[1] ? st_r.ioSy[1] : 1'b0, st_r.cmd[23:1]};
					if (clkRise && st_r.bitCnt < CMD_CLKS + 6'h01)
						st_nxt.bitCnt = st_r.bitCnt + 6'h01;
					if (startC)
						st_nxt.bitCnt = '0;
					// wrong count or command leaves the line high
					if (stopC) begin
						st_nxt.mode = M_IDLE;
						if (st_r.bitCnt == CMD_CLKS) begin
							st_nxt.tclk = '0;
							st_nxt.timer = '0;
							st_nxt.haveByte = 1'b0;
							case (st_r.cmd.ctrl)
								CTL_RD_MAIN: begin
									st_nxt.mode = M_OUT;
									st_nxt.pfKind = K_MAIN;
									st_nxt.pfAddr = st_r.cmd.addr;
									st_nxt.pfLeft = MAIN_SIZE - {1'b0, st_r.cmd.addr};
								end
								CTL_RD_PROT, CTL_RD_SEC: begin
									st_nxt.mode = M_OUT;
									st_nxt.pfKind = (st_r.cmd.ctrl == CTL_RD_PROT) ? K_PROT : K_SEC;
									st_nxt.pfAddr = '0;
									st_nxt.pfLeft = AUX_BYTES;
								end
								default: begin
									if (!wrBlock) begin
										st_nxt.mode = M_PROC;
										if (st_r.cmd.ctrl == CTL_COMPARE) begin
											st_nxt.cmpStep = st_r.cmpStep + 2'h1;
											if (st_r.cmpStep == 2'h3)
												st_nxt.unlocked = 1'b1;
											st_nxt.tclkGoal = 9'h001;
										end else begin
											if (st_r.cmd.ctrl == CTL_UPD_SEC && !st_r.unlocked)
												st_nxt.cmpStep = 2'h1;
											st_nxt.eraseP = needErase && st_r.cmd.ctrl != CTL_WR_PROT;
											st_nxt.writeP = needWrite || st_r.cmd.ctrl == CTL_WR_PROT;
											// terminal clock count per update kind
											st_nxt.tclkGoal = (needErase && needWrite) ? CLK_BOTH
												: (needErase || needWrite || st_r.cmd.ctrl == CTL_WR_PROT)
												? CLK_ONE : 9'h001;
										end
									end else if (st_r.cmd.ctrl == CTL_COMPARE) begin
										st_nxt.cmpStep = 2'h0;
									end
								end
							endcase
						end
					end
				end
				// first bit on first fall, extra clock releases
				M_OUT: begin
					if (clkFall) begin
						if (st_r.haveByte && st_r.outBit != 3'h7) begin
							st_nxt.outBit = st_r.outBit + 3'h1;
							st_nxt.oeN = st_r.outByte[st_r.outBit + 3'h1];
						end else if (popV) begin
							popR = 1'b1;
							st_nxt.outByte = popD;
							st_nxt.outBit = 3'h0;
							st_nxt.haveByte = 1'b1;
							st_nxt.oeN = popD[0];
						end else if (st_r.pfLeft == 9'h000) begin
							st_nxt.oeN = 1'b1;
							st_nxt.haveByte = 1'b0;
							st_nxt.mode = M_IDLE;
						end
					end
				end
				// low from first fall until work done
				M_PROC: begin
					if (clkFall && st_r.tclk == 9'h000)
						st_nxt.oeN = 1'b0;
					else if (clkFall && !st_r.eraseP && !st_r.writeP
						&& st_r.tclk >= st_r.tclkGoal) begin
						st_nxt.oeN = 1'b1;
						st_nxt.mode = M_IDLE;
					end
				end
				default: st_nxt.mode = M_IDLE;
			endcase
		end
	end

	// State register; memories start erased, code at its blank value
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.oeN <= 1'b1;
			st_r.mem <= {256{MEM_RESET}};
			st_r.sec <= {CODE_RESET, EC_RESET};
		end else begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_atr_last;
		st_r.mode == M_ATR && clkFall && st_r.bitCnt == 6'h1f && !rstHi && !rstFall;
	endsequence
	property p_atr_end;
		s_atr_last |=> st_r.oeN && st_r.mode == M_IDLE;
	endproperty
	a_atr_end: assert property (p_atr_end) else $error("ATR did not release");

	property p_break;
		rstRise && !clkHi |=> st_r.oeN && st_r.mode == M_IDLE && !st_r.eraseP;
	endproperty
	a_break: assert property (p_break) else $error("Break did not abort");

	sequence s_proc_first;
		st_r.mode == M_PROC && clkFall && st_r.tclk == 9'h000 && !rstHi && !rstRise;
	endsequence
	property p_proc_low;
		s_proc_first |=> !st_r.oeN ##1 !st_r.oeN;
	endproperty
	a_proc_low: assert property (p_proc_low) else $error("Busy not shown");

	property p_phase;
		($fell(st_r.eraseP) || $fell(st_r.writeP)) && !$past(breakNow) |->
			$past(st_r.timer) == 17'(PHASE_CYC - 1);
	endproperty
	a_phase: assert property (p_phase) else $error("Phase too short");

	property p_prot_keep;
		($past(st_r.prot) & ~st_r.prot) == 32'h0;
	endproperty
	a_prot_keep: assert property (p_prot_keep) else $error("Protection bit lost");

	property p_erase_ones;
		$fell(st_r.eraseP) && !$past(breakNow) && st_r.cmd.ctrl == CTL_UPD_MAIN |->
			st_r.mem[st_r.cmd.addr] == 8'hff;
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("Erase not all ones");

	property p_write_and;
		$fell(st_r.writeP) && !$past(breakNow) && st_r.cmd.ctrl == CTL_UPD_MAIN |->
			st_r.mem[st_r.cmd.addr] == ($past(st_r.mem[st_r.cmd.addr]) & st_r.cmd.data);
	endproperty
	a_write_and: assert property (p_write_and) else $error("Write not AND");

	property p_locked;
		!st_r.unlocked |=> st_r.mem == $past(st_r.mem);
	endproperty
	a_locked: assert property (p_locked) else $error("Locked memory changed");

	property p_line_edge;
		$changed(st_r.oeN) |-> $past(clkFall || rstRise || rstFall || rstHi);
	endproperty
	a_line_edge: assert property (p_line_edge) else $error("Line moved off edge");
endmodule : card_chip
`default_nettype wire

// file: verification/terminal_model.sv
// Behavioural card reader terminal driving the clock, reset and data pins
`timescale 1ns/1ps
`default_nettype none

module terminal_model (
	input  wire logic ref_clk,
	input  wire logic ioLine,
	output logic      cardClk,
	output logic      cardRst,
	output logic      ioDrv
);
	// Long pin phases so the card's synchronisers always settle
	localparam int HALF = 8;

	// Pins idle: clock low, reset low, data released to the pull-up
	initial begin
		cardClk = 1'b0;
		cardRst = 1'b0;
		ioDrv   = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : hold

	// sample in high phase
	// Card output only moves after a fall, so late high phase is safe
	task automatic pulse(output logic b);
		cardClk <= 1'b1;
		hold(HALF);
		b = ioLine;
		cardClk <= 1'b0;
		hold(HALF);
	endtask : pulse

	task automatic sendCmd(input logic [7:0] ctrl, input logic [7:0] addr,
		input logic [7:0] data);
		logic [23:0] word;
		logic        d;
		word = {data, addr, ctrl};
		cardClk <= 1'b1;
		hold(HALF);
		ioDrv <= 1'b0;
		hold(HALF);
		cardClk <= 1'b0;
		hold(HALF);
		// Data only changes while the clock is low, LSB first
		for (int i = 0; i < 24; i++) begin
			ioDrv <= word[i];
			hold(HALF);
			pulse(d);
		end
		ioDrv <= 1'b0;
		hold(HALF);
		cardClk <= 1'b1;
		hold(HALF);
		ioDrv <= 1'b1;
		hold(HALF);
		cardClk <= 1'b0;
		hold(HALF);
	endtask : sendCmd

	task automatic read32(output logic [31:0] v, output logic tail);
		logic b;
		for (int i = 0; i < 32; i++) begin
			pulse(b);
			v[i] = b;
		end
		pulse(tail);
	endtask : read32

	// reset then answer
	// Reset rises with the clock low, which doubles as a break
	task automatic answerReset(output logic brk, output logic [31:0] v, output logic tail);
		cardRst <= 1'b1;
		hold(HALF);
		brk = ioLine;
		cardClk <= 1'b1;
		hold(HALF);
		cardClk <= 1'b0;
		hold(HALF);
		cardRst <= 1'b0;
		hold(HALF);
		read32(v, tail);
	endtask : answerReset

	// clock until released
	// Bounded so a card that never lets go cannot hang the run
	task automatic processWait(output int q);
		logic b;
		q = 0;
		b = 1'b0;
		while (!b && q < 400) begin
			pulse(b);
			q++;
		end
	endtask : processWait
endmodule : terminal_model
`default_nettype wire

// file: verification/test_card_chip.sv
// Self-checking bench for the card chip protocol engine
`timescale 1ns/1ps
`default_nettype none

module test_card_chip;
	import card_mem_pkg::*;

	localparam int CYC_ONE  = int'(CLK_ONE);
	localparam int CYC_BOTH = int'(CLK_BOTH);

	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cardClk;
	logic        cardRst;
	logic        ioDrv;
	logic        ioOut;
	logic        ioOe_n;
	logic        ioLine;
	logic [31:0] v;
	logic        t;
	logic        brk;
	int          q;
	int          bad_count = 0;
	int          checks = 0;

	// Open drain wire: pull-up unless either party pulls low
	assign ioLine = (ioOe_n ? 1'b1 : ioOut) & ioDrv;

	always #25 ref_clk = ~ref_clk;

	// Short phase time keeps the clock count, not the timer, in charge
	card_chip #(.PHASE_CYC(20)) dut (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cardClk(cardClk),
		.cardRst(cardRst),
		.ioIn   (ioLine),
		.ioOut  (ioOut),
		.ioOe_n (ioOe_n)
	);

	terminal_model term (
		.ref_clk(ref_clk),
		.ioLine (ioLine),
		.cardClk(cardClk),
		.cardRst(cardRst),
		.ioDrv  (ioDrv)
	);

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmpByte

	// A count at the wait bound means the line never came back
	task automatic cmpCount(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, lo);
		end
		if (got >= 400)
			conclude();
	endtask : cmpCount

	task automatic cmdProc(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
		input int lo, input int hi);
		term.sendCmd(c, a, d);
		term.processWait(q);
		cmpCount(q, lo, hi);
	endtask : cmdProc

	task automatic cmdRead(input logic [7:0] c, input logic [7:0] a);
		term.sendCmd(c, a, 8'h00);
		term.read32(v, t);
	endtask : cmdRead

	task automatic testLocked();
		cmdProc(CTL_UPD_MAIN, 8'hfe, 8'h00, 1, 1);
		cmdRead(CTL_RD_MAIN, 8'hfc);
		cmpByte(v[23:16], MEM_RESET);
		cmpByte({7'h00, t}, 8'h01);
		cmdRead(CTL_RD_SEC, 8'h00);
		cmpByte(v[7:0], EC_RESET);
		cmpByte(v[15:8], 8'h00);
		$display("test locked done");
	endtask : testLocked

	task automatic testUnlock();
		cmdProc(CTL_UPD_SEC, 8'h00, 8'h06, CYC_ONE, CYC_ONE + 2);
		for (int a = 1; a < 4; a++)
			cmdProc(CTL_COMPARE, 8'(a), 8'hff, 2, 2);
		cmdRead(CTL_RD_SEC, 8'h00);
		cmpByte(v[7:0], 8'h06);
		cmpByte(v[31:24], CODE_RESET[23:16]);
		$display("test unlock done");
	endtask : testUnlock

	// Write only, erase and write, write only, erase only
	task automatic testUpdate();
		logic [7:0] dat [4] = '{8'h5a, 8'ha5, 8'h21, 8'hff};
		int         cyc [4] = '{CYC_ONE, CYC_BOTH, CYC_ONE, CYC_ONE};
		for (int i = 0; i < 4; i++) begin
			cmdProc(CTL_UPD_MAIN, 8'hfe, dat[i], cyc[i], cyc[i] + 2);
			cmdRead(CTL_RD_MAIN, 8'hfc);
			cmpByte(v[23:16], dat[i]);
		end
		$display("test update done");
	endtask : testUpdate

	task automatic testProtect();
		cmdProc(CTL_WR_PROT, 8'h01, 8'hff, CYC_ONE, CYC_ONE + 2);
		cmdRead(CTL_RD_PROT, 8'h00);
		cmpByte(v[7:0], 8'h02);
		cmdProc(CTL_UPD_MAIN, 8'h01, 8'h00, 1, 1);
		cmdProc(CTL_WR_PROT, 8'h01, 8'hff, 1, 1);
		cmdProc(8'h35, 8'h00, 8'h00, 1, 1);
		cmdProc(CTL_UPD_MAIN, 8'h00, 8'h5a, CYC_ONE, CYC_ONE + 2);
		$display("test protect done");
	endtask : testProtect

	// Break an update in flight, then check the answer-to-reset bytes
	task automatic testBreak();
		term.sendCmd(CTL_UPD_MAIN, 8'h02, 8'h00);
		cmpByte({7'h00, ioLine}, 8'h00);
		term.answerReset(brk, v, t);
		cmpByte({7'h00, brk}, 8'h01);
		cmpByte(v[7:0], 8'h5a);
		cmpByte(v[15:8], 8'hff);
		cmpByte({7'h00, t}, 8'h01);
		$display("test break done");
	endtask : testBreak

	// Three error counter writes, each followed by a failed compare, spend the counter for good
	task automatic testCounter();
		logic [7:0] ec [3] = '{8'h06, 8'h04, 8'h00};
		reset_n <= 1'b0;
		term.hold(2);
		reset_n <= 1'b1;
		term.hold(2);
		for (int i = 0; i < 3; i++) begin
			cmdProc(CTL_UPD_SEC, 8'h00, ec[i], CYC_ONE, CYC_ONE + 2);
			term.sendCmd(CTL_COMPARE, 8'h01, 8'h00);
			term.processWait(q);
			cmpCount(q, 1, 1);
		end
		cmdProc(CTL_COMPARE, 8'h01, 8'hff, 1, 1);
		cmdProc(CTL_UPD_MAIN, 8'hfe, 8'h00, 1, 1);
		cmdRead(CTL_RD_SEC, 8'h00);
		cmpByte(v[7:0], 8'h00);
		$display("test counter done");
	endtask : testCounter

	// Main sequence: reset, then each scenario in order
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		term.hold(2);
		testLocked();
		testUnlock();
		testUpdate();
		testProtect();
		testBreak();
		testCounter();
		conclude();
	end
endmodule : test_card_chip
`default_nettype wire
